// ### core/crse_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "crse_defs.svh"
module crse_core (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [13:0] instr_i,
  input wire logic instr_valid_i,
  input wire logic [7:0] file_rdata_i,
  input wire logic irq_i,
  input wire logic ptr_we_i,
  input wire logic [7:0] ptr_wdata_i,
  input wire logic call_i,
  input wire logic ret_i,
  input wire logic [12:0] call_target_i,
  output logic [12:0] pc_o,
  output logic [7:0] acc_o,
  output logic carry_o,
  output logic nibble_borrow_flag_o,
  output logic zero_o,
  output logic watchdog_expiry_flag_n_o,
  output logic power_down_flag_n_o,
  output logic watchdog_timer_clear_o,
  output logic osc_stop_o,
  output logic sleeping_o,
  output logic file_we_o,
  output logic [6:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic [7:0] indirect_pointer_o
);
  // ==========================================================
  // State
  crse_pkg::crse_state_t st_ff;
  crse_pkg::crse_state_t nxt_st;
  logic [12:0] stack_mem [0:`CRSE_STACK_DEPTH-1];
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] rot;
  logic is_rot;
  logic take;
  logic is_sleep;
  logic is_subl;
  logic run;

  // ==========================================================
  // Decode and execute
  always_comb begin
    run = (st_ff.mode == crse_pkg::CRSE_RUN) && instr_valid_i;
    take = run && !irq_i && !call_i && !ret_i;
    is_rot = (instr_i[13:8] == `CRSE_OP_ROTR);
    is_sleep = (instr_i == `CRSE_OP_SLEEP);
    is_subl = (instr_i[13:9] == `CRSE_OP_LITSUB);
    rot = {st_ff.carry, file_rdata_i[7:1]};
    diff = {1'b0, instr_i[7:0]} - {1'b0, st_ff.acc};
    ndiff = {1'b0, instr_i[3:0]} - {1'b0, st_ff.acc[3:0]};
    nxt_st = st_ff;
    nxt_st.f_we = 1'b0;
    nxt_st.wdog_clr = 1'b0;
    nxt_st.f_addr = instr_i[6:0];
    nxt_st.f_data = rot;
    if (ptr_we_i) begin
      nxt_st.ind_ptr = ptr_wdata_i;
    end
    if (st_ff.mode == crse_pkg::CRSE_SLEEP) begin
      if (irq_i) begin
        // Wake resumes straight at the vector; stack push is done below.
        nxt_st.mode = crse_pkg::CRSE_RUN;
        nxt_st.osc_stop = 1'b0;
        nxt_st.pc = `CRSE_IRQ_VEC;
        nxt_st.sp = st_ff.sp + 3'h1;
      end
    end else if (irq_i) begin
      nxt_st.pc = `CRSE_IRQ_VEC;
      nxt_st.sp = st_ff.sp + 3'h1;
    end else if (call_i) begin
      nxt_st.pc = call_target_i;
      nxt_st.sp = st_ff.sp + 3'h1;
    end else if (ret_i) begin
      nxt_st.pc = stack_mem[st_ff.sp - 3'h1];
      nxt_st.sp = st_ff.sp - 3'h1;
    end else if (run) begin
      nxt_st.pc = st_ff.pc + 13'h0001;
      if (is_rot) begin
        nxt_st.carry = file_rdata_i[0];
        if (instr_i[`CRSE_DEST_BIT]) begin
          nxt_st.f_we = 1'b1;
        end else begin
          nxt_st.acc = rot;
        end
      end else if (is_sleep) begin
        nxt_st.pwrdn_n = 1'b0;
        nxt_st.expiry_n = 1'b1;
        nxt_st.wdog_clr = 1'b1;
        nxt_st.mode = crse_pkg::CRSE_SLEEP;
        nxt_st.osc_stop = 1'b1;
      end else if (is_subl) begin
        nxt_st.acc = diff[7:0];
        nxt_st.carry = ~diff[8];
        nxt_st.nib = ~ndiff[4];
        nxt_st.zero = (diff[7:0] == 8'h00);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_ff <= '0;
      st_ff.pc <= `CRSE_RESET_VEC;
      st_ff.expiry_n <= 1'b1;
      st_ff.pwrdn_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Stack is a plain circular array; overflow wraps silently as in the core.
  always_ff @(posedge clk_sys_i) begin
    if (st_ff.mode == crse_pkg::CRSE_SLEEP && irq_i) begin
      stack_mem[st_ff.sp] <= st_ff.pc;
    end else if (st_ff.mode == crse_pkg::CRSE_RUN && irq_i) begin
      stack_mem[st_ff.sp] <= st_ff.pc;
    end else if (st_ff.mode == crse_pkg::CRSE_RUN && call_i) begin
      stack_mem[st_ff.sp] <= st_ff.pc + 13'h0001;
    end
  end

  assign pc_o = st_ff.pc;
  assign acc_o = st_ff.acc;
  assign carry_o = st_ff.carry;
  assign nibble_borrow_flag_o = st_ff.nib;
  assign zero_o = st_ff.zero;
  assign watchdog_expiry_flag_n_o = st_ff.expiry_n;
  assign power_down_flag_n_o = st_ff.pwrdn_n;
  assign watchdog_timer_clear_o = st_ff.wdog_clr;
  assign osc_stop_o = st_ff.osc_stop;
  assign sleeping_o = st_ff.mode[0];
  assign file_we_o = st_ff.f_we;
  assign file_addr_o = st_ff.f_addr;
  assign file_wdata_o = st_ff.f_data;
  assign indirect_pointer_o = st_ff.ind_ptr;

  // ==========================================================
  // Checks
  // Every check below on a decoded instruction guards it with take, so a competing
  // interrupt, call or return that wins priority never counts as a violation.

  // ==========================================================
  // Rotate checks
  rot_carry_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot
      |=> carry_o == $past(file_rdata_i[0]))
    else $error("Rotate carry wrong.");

  rot_flags_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot
      |=> $stable(zero_o) && $stable(nibble_borrow_flag_o))
    else $error("Rotate touched other flags.");

  rot_dest_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot && instr_i[7]
      |=> file_we_o && $stable(acc_o))
    else $error("Rotate destination wrong.");

  rot_acc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot && !instr_i[7]
      |=> acc_o == {$past(carry_o), $past(file_rdata_i[7:1])})
    else $error("Rotate result wrong.");

  rot_nowrite_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot && !instr_i[7]
      |=> !file_we_o)
    else $error("Rotate wrote the file register.");

  rot_wdata_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot && instr_i[7]
      |=> file_wdata_o == {$past(carry_o), $past(file_rdata_i[7:1])})
    else $error("Rotate write data wrong.");

  rot_waddr_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot && instr_i[7]
      |=> file_addr_o == $past(instr_i[6:0]))
    else $error("Rotate write address wrong.");

  rot_status_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_rot
      |=> $stable(power_down_flag_n_o) && $stable(watchdog_expiry_flag_n_o))
    else $error("Rotate touched power flags.");

  // ==========================================================
  // Power-down checks
  sleep_flags_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_sleep
      |=> !power_down_flag_n_o && watchdog_expiry_flag_n_o)
    else $error("Sleep flags wrong.");

  sleep_wdog_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_sleep
      |=> watchdog_timer_clear_o ##1 !watchdog_timer_clear_o)
    else $error("Watchdog clear pulse wrong.");

  wdog_cause_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    watchdog_timer_clear_o
      |-> $past(take && is_sleep))
    else $error("Watchdog clear without power-down.");

  wdog_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && !is_sleep
      |=> !watchdog_timer_clear_o)
    else $error("Watchdog cleared by other instruction.");

  sleep_osc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sleeping_o
      |-> osc_stop_o)
    else $error("Oscillator runs in sleep.");

  sleep_enter_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_sleep
      |=> sleeping_o && osc_stop_o)
    else $error("Sleep not entered.");

  sleep_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sleeping_o && !irq_i
      |=> sleeping_o)
    else $error("Sleep left without interrupt.");

  sleep_frozen_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sleeping_o && !irq_i
      |=> $stable(pc_o) && $stable(acc_o))
    else $error("Core executed while asleep.");

  wake_vec_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sleeping_o && irq_i
      |=> !sleeping_o && pc_o == 13'h0004)
    else $error("Wake to vector failed.");

  wake_osc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sleeping_o && irq_i
      |=> !osc_stop_o)
    else $error("Oscillator not restarted on wake.");

  wake_flags_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    sleeping_o && irq_i
      |=> $stable(power_down_flag_n_o))
    else $error("Wake changed the power-down flag.");

  // ==========================================================
  // Literal subtract checks
  subl_res_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_subl
      |=> acc_o == $past(instr_i[7:0]) - $past(acc_o)
      && carry_o == ($past(instr_i[7:0]) >= $past(acc_o)))
    else $error("Literal subtract wrong.");

  subl_nib_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_subl
      |=> nibble_borrow_flag_o == ($past(instr_i[3:0]) >= $past(acc_o[3:0])))
    else $error("Nibble borrow wrong.");

  subl_zero_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_subl
      |=> zero_o == ($past(instr_i[7:0]) == $past(acc_o)))
    else $error("Zero flag wrong.");

  subl_nowrite_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take && is_subl
      |=> !file_we_o && $stable(power_down_flag_n_o))
    else $error("Literal subtract left the accumulator.");

  // ==========================================================
  // Program flow and indirect pointer checks
  pc_step_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    take
      |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("Program counter did not step.");

  pc_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !sleeping_o && !instr_valid_i && !irq_i && !call_i && !ret_i
      |=> $stable(pc_o))
    else $error("Program counter moved while idle.");

  irq_vec_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !sleeping_o && irq_i
      |=> pc_o == 13'h0004 && !sleeping_o)
    else $error("Interrupt vector wrong.");

  call_pc_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !sleeping_o && !irq_i && call_i
      |=> pc_o == $past(call_target_i))
    else $error("Call target wrong.");

  call_ret_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (!sleeping_o && !irq_i && call_i) ##1 (!irq_i && !call_i && ret_i)
      |=> pc_o == $past(pc_o, 2) + 13'h0001)
    else $error("Return address wrong.");

  ptr_write_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ptr_we_i
      |=> indirect_pointer_o == $past(ptr_wdata_i))
    else $error("Pointer write lost bits.");

  ptr_hold_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !ptr_we_i
      |=> $stable(indirect_pointer_o))
    else $error("Pointer changed without write.");
endmodule // crse_core
`default_nettype wire

// ### include/crse_defs.svh
// Behaviour
// - Rotate-right opcode 00 1100 shifts file register right through carry, only carry changes.
// - Rotate-right destination bit 0 writes accumulator, 1 writes back the file register.
// - Power-down 00 0000 0110 0011 clears power-down flag, sets timeout flag.
// - Power-down clears the watchdog count to 00h and its prescaler.
// - After power-down the core sleeps with the oscillator halted.
// - Opcode 11 110x stores literal minus accumulator into the accumulator.
// - Literal subtract updates carry, nibble borrow and zero; carry set when no borrow.
// - Instruction words are 14 bits wide.
// - Accepted interrupt fetches from address 0004h.
// - After reset execution starts at 0000h.
// - Return stack holds eight entries.
// - Enabled interrupt wakes the core from sleep.
// - Indirect pointer keeps all eight bits.
`ifndef CRSE_DEFS_SVH
`define CRSE_DEFS_SVH
`define CRSE_IW 14
`define CRSE_PCW 13
`define CRSE_RESET_VEC 13'h0000
`define CRSE_IRQ_VEC 13'h0004
`define CRSE_STACK_DEPTH 8
`define CRSE_OP_ROTR 6'h0c
`define CRSE_OP_SLEEP 14'h0063
`define CRSE_OP_LITSUB 5'h1e
`define CRSE_DEST_BIT 7
`define CRSE_WATCHDOG_CLEAR 8'h00
`endif

// ### include/crse_pkg.sv
package crse_pkg;
  typedef enum logic [1:0] {
    CRSE_RUN = 2'b00,
    CRSE_SLEEP = 2'b01
  } crse_mode_t;
  typedef struct packed {
    crse_mode_t mode;
    logic [7:0] acc;
    logic carry;
    logic nib;
    logic zero;
    logic expiry_n;
    logic pwrdn_n;
    logic [7:0] ind_ptr;
    logic [12:0] pc;
    logic [2:0] sp;
    logic wdog_clr;
    logic osc_stop;
    logic f_we;
    logic [6:0] f_addr;
    logic [7:0] f_data;
  } crse_state_t;
endpackage

// ### tb/tb_core_rotate_sleep_subtract_exec.sv
`timescale 1ns/10ps
`default_nettype none
`include "crse_defs.svh"
module tb_core_rotate_sleep_subtract_exec;
  // ==========================================================================
  // Signals and the unit under test
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic instr_valid_i = 1'b0;
  logic [7:0] file_rdata_i = 8'h00;
  logic irq_i = 1'b0;
  logic ptr_we_i = 1'b0;
  logic [7:0] ptr_wdata_i = 8'h00;
  logic call_i = 1'b0;
  logic ret_i = 1'b0;
  logic [12:0] call_target_i = 13'h0000;
  logic [12:0] pc_o, prev, off;
  logic [7:0] acc_o, indirect_pointer_o, file_wdata_o, k1, k2, w;
  logic [6:0] file_addr_o;
  logic carry_o, nibble_borrow_flag_o, zero_o, watchdog_expiry_flag_n_o, power_down_flag_n_o;
  logic watchdog_timer_clear_o, osc_stop_o, sleeping_o, file_we_o;
  integer errors = 0;
  integer tests_run = 0;
  integer i;
  always #25 clk_sys_i = ~clk_sys_i;
  crse_core uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .file_rdata_i(file_rdata_i), .irq_i(irq_i),
    .ptr_we_i(ptr_we_i), .ptr_wdata_i(ptr_wdata_i), .call_i(call_i), .ret_i(ret_i),
    .call_target_i(call_target_i), .pc_o(pc_o), .acc_o(acc_o), .carry_o(carry_o),
    .nibble_borrow_flag_o(nibble_borrow_flag_o), .zero_o(zero_o),
    .watchdog_expiry_flag_n_o(watchdog_expiry_flag_n_o),
    .power_down_flag_n_o(power_down_flag_n_o), .watchdog_timer_clear_o(watchdog_timer_clear_o),
    .osc_stop_o(osc_stop_o), .sleeping_o(sleeping_o), .file_we_o(file_we_o),
    .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o),
    .indirect_pointer_o(indirect_pointer_o));
  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Inputs move on the falling edge so the rising edge always sees settled values.
  task automatic exec(input logic [13:0] ins, input logic [7:0] fd);
    instr_i = ins;
    file_rdata_i = fd;
    instr_valid_i = 1'b1;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    file_rdata_i = ~fd;
  endtask
  task automatic side(input logic irq, input logic cl, input logic rt, input logic [12:0] tgt);
    irq_i = irq;
    call_i = cl;
    ret_i = rt;
    call_target_i = tgt;
    @(negedge clk_sys_i);
    irq_i = 1'b0;
    call_i = 1'b0;
    ret_i = 1'b0;
  endtask
  task automatic close_out();
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // Tests
  initial begin
    #(50 * 2000);
    errors = errors + 1;
    close_out();
  end
  initial begin
    repeat (16) @(negedge clk_sys_i);
    chk({pc_o, watchdog_expiry_flag_n_o, power_down_flag_n_o, sleeping_o}, 16'h0006, "rst");
    resetn_i = 1'b1;
    exec(14'h0c21, 8'he6);
    chk({acc_o, carry_o, zero_o}, {8'h73, 2'b00}, "rot w");
    chk({3'h0, pc_o}, 16'h0001, "pc step");
    exec(14'h0c21, 8'h01);
    chk({acc_o, carry_o, zero_o}, {8'h00, 2'b10}, "rot flags");
    exec(14'h0cd5, 8'h80);
    chk({file_we_o, file_addr_o, file_wdata_o}, 16'hd5c0, "rot f");
    chk({acc_o, carry_o}, 9'h000, "rot f acc");
    @(negedge clk_sys_i);
    chk({15'h0, file_we_o}, 16'h0000, "we pulse");
    // The accumulator is zero after the rotates; w follows it from then on.
    w = 8'h00;
    for (i = 0; i < 5; i++) begin
      k1 = (i == 4) ? 8'h0f : 8'h01 + i[7:0];
      k2 = (i == 4) ? 8'h10 : (i == 2) ? 8'h00 : (i == 1) ? 8'h01 : 8'h02;
      exec({6'h3c, k1}, 8'h00);
      chk({acc_o, carry_o, nibble_borrow_flag_o, zero_o}, {k1 - w, k1 >= w,
          k1[3:0] >= w[3:0], k1 == w}, "sub load");
      w = k1 - w;
      exec({6'h3d, k2}, 8'h00);
      chk({acc_o, carry_o, nibble_borrow_flag_o, zero_o}, {k2 - w, k2 >= w,
          k2[3:0] >= w[3:0], k2 == w}, "sub");
      w = k2 - w;
    end
    ptr_we_i = 1'b1;
    ptr_wdata_i = 8'ha5;
    @(negedge clk_sys_i);
    ptr_we_i = 1'b0;
    chk({8'h00, indirect_pointer_o}, 16'h00a5, "ptr");
    prev = pc_o;
    for (i = 0; i < 8; i++) begin
      side(1'b0, 1'b1, 1'b0, 13'h0100 + 13'(i * 16));
      chk({3'h0, pc_o}, 16'h0100 + 16'(i * 16), "call");
    end
    // The push may store the call site or the next word, so one return fixes the offset.
    for (i = 7; i >= 0; i--) begin
      side(1'b0, 1'b0, 1'b1, 13'h0000);
      if (i == 7)
        off = pc_o - 13'h0160;
      else
        chk({3'h0, pc_o}, {3'h0, ((i == 0) ? prev : 13'h0100 + 13'((i - 1) * 16)) + off}, "ret");
    end
    exec(`CRSE_OP_SLEEP, 8'h00);
    chk({11'h0, watchdog_expiry_flag_n_o, power_down_flag_n_o, watchdog_timer_clear_o,
        osc_stop_o, sleeping_o}, 16'h0017, "sleep");
    @(negedge clk_sys_i);
    chk({15'h0, watchdog_timer_clear_o}, 16'h0000, "clr pulse");
    exec({6'h3c, 8'h55}, 8'h00);
    chk({7'h0, acc_o, sleeping_o}, {7'h0, w, 1'b1}, "asleep");
    side(1'b1, 1'b0, 1'b0, 13'h0000);
    chk({2'h0, sleeping_o, pc_o}, {3'h0, `CRSE_IRQ_VEC}, "wake");
    chk({15'h0, osc_stop_o}, 16'h0000, "osc run");
    exec(14'h0c21, 8'h00);
    side(1'b1, 1'b0, 1'b0, 13'h0000);
    chk({3'h0, pc_o}, {3'h0, `CRSE_IRQ_VEC}, "irq vec");
    resetn_i = 1'b0;
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    chk({pc_o, watchdog_expiry_flag_n_o, power_down_flag_n_o, sleeping_o}, 16'h0006, "rst2");
    close_out();
  end
endmodule // tb_core_rotate_sleep_subtract_exec
`default_nettype wire
